//--- verilog/sacp_defines.svh
`ifndef SACP_DEFINES_SVH
`define SACP_DEFINES_SVH

// ==========================================================================
// widths
`define SACP_RES_W        10
`define SACP_WORD_W       16
`define SACP_CFG_W        8
`define SACP_CNT_W        5
`define SACP_FCNT_W       4
`define SACP_FIFO_DEPTH   4

// ==========================================================================
// configuration word fields, first bit received lands in bit 7
`define SACP_MUX_HI       7
`define SACP_MUX_LO       4
`define SACP_UNI_BIT      3
`define SACP_ORDER_BIT    2
`define SACP_LEN_HI       1
`define SACP_LEN_LO       0
`define SACP_CFG_LAST     5'h07

// ==========================================================================
// word length codes and their bit counts
`define SACP_LEN_8        2'h0
`define SACP_LEN_10       2'h1
`define SACP_LEN_12       2'h2
`define SACP_LEN_16       2'h3
`define SACP_BITS_8       5'h08
`define SACP_BITS_10      5'h0a
`define SACP_BITS_12      5'h0c
`define SACP_BITS_16      5'h10

// ==========================================================================
// chip select deglitch and reset values
`define SACP_CS_FALLS     2'h2
`define SACP_SYNC_RST     3'h1
`define SACP_ORDER_RST    1'h1
`define SACP_UNI_RST      1'h1

`endif

//--- verilog/sacp_pkg.sv
`include "sacp_defines.svh"

package sacp_pkg;

  // ========================================================================
  // control states
  typedef enum logic [2:0] {
    sacp_idle = 3'h1,
    sacp_xfer = 3'h2,
    sacp_conv = 3'h4
  } sacp_state_type;

  typedef logic [1:0] sacp_len_type;

  // ========================================================================
  // word length code to count of shift clocks
  function automatic logic [`SACP_CNT_W-1:0] sacp_len_bits(
    input sacp_len_type sel
  );
    logic [`SACP_CNT_W-1:0] n;
    n = `SACP_BITS_8;
    unique case (sel)
      `SACP_LEN_8:  n = `SACP_BITS_8;
      `SACP_LEN_10: n = `SACP_BITS_10;
      `SACP_LEN_12: n = `SACP_BITS_12;
      `SACP_LEN_16: n = `SACP_BITS_16;
    endcase
    return n;
  endfunction : sacp_len_bits

endpackage : sacp_pkg

//--- verilog/sacp_stream_if.sv
`timescale 1ns/1ns

interface sacp_stream_if #(
  parameter int W = 10
) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface : sacp_stream_if

//--- verilog/sacp_fifo.sv
`timescale 1ns/1ns

module sacp_fifo
  import sacp_pkg::*;
#(
  parameter int W     = 10,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // draining side
  sacp_stream_if.source     rd
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_q [DEPTH];
  logic [W-1:0]  mem_d [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] wr_d;
  logic [AW-1:0] rd_q;
  logic [AW-1:0] rd_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          push;
  logic          pop;

  // ========================================================================
  // flags: full stalls the filling side, so the converter sees back-pressure
  assign in_ready = (cnt_q != CW'(DEPTH));
  assign rd.valid = (cnt_q != '0);
  assign rd.data  = mem_q[rd_q];

  always_comb begin
    push  = in_valid & in_ready;
    pop   = rd.valid & rd.ready;
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : AW'(wr_q + 1'b1);
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : AW'(rd_q + 1'b1);
    end
    if (push && !pop) begin
      cnt_d = CW'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = CW'(cnt_q - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

endmodule : sacp_fifo

//--- verilog/sacp_control_port.sv
// Contract
// - bipolar results are two's complement; the offset code has its msb flipped
// - sixth config bit 1 gives msb-first output, 0 gives lsb-first
// - bit order from one config word applies to the next output word
// - the config word itself is always received first-bit-first
// - the last two config bits choose 8, 10, 12 or 16 bit words
// - word length applies to the output word of the same transfer
// - chip select changes shorter than one conversion clock are ignored
// - new chip select level valid after two falling conversion clock edges
// - recognized low chip select drives serial output out of high-z
// - shift clock activity is ignored while chip select is high
// - held chip select low: output drives first bit when conversion ends
// - 16-bit words send ten result bits then six zeros
// - output changes after falling shift edge, input sampled on rising edge
// - config taken on first eight rising edges, later input ignored
// - fifth config bit 1 means unipolar, 0 bipolar conversion
// - conversion starts at end of exchange; result shown in the next exchange
`timescale 1ns/1ns
`include "sacp_defines.svh"

module sacp_control_port
  import sacp_pkg::*;
#(
  parameter int RES_W      = `SACP_RES_W,
  parameter int FIFO_DEPTH = `SACP_FIFO_DEPTH
) (
  // system
  input  wire logic             clk,
  input  wire logic             resetn,
  // serial link
  input  wire logic             sclk,
  input  wire logic             cs_n,
  input  wire logic             din,
  input  wire logic             aclk,
  output logic                  dout,
  output logic                  dout_oe_n,
  // conversion request
  output logic                  conv_start,
  output logic [3:0]            conv_mux,
  output logic                  conv_unipolar,
  // conversion result
  input  wire logic             res_valid,
  output logic                  res_ready,
  input  wire logic [RES_W-1:0] res_data,
  // status
  output logic                  busy,
  output logic                  cs_active
);

  localparam int WORD_W = `SACP_WORD_W;
  localparam int CFG_W  = `SACP_CFG_W;

  // ========================================================================
  // reset release
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'h0;
      rst_n_q    <= 1'h0;
    end else begin
      rst_meta_q <= 1'h1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ========================================================================
  // pin synchronisers: {exchange done, conversion clock, chip select}
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic       aclk_prev_q;
  logic       done_lvl;
  logic       cs_s;
  logic       aclk_s;
  logic       done_s;
  logic       aclk_fall;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sync1_q     <= `SACP_SYNC_RST;
      sync2_q     <= `SACP_SYNC_RST;
      aclk_prev_q <= 1'h0;
    end else begin
      sync1_q     <= {done_lvl, aclk, cs_n};
      sync2_q     <= sync1_q;
      aclk_prev_q <= sync2_q[1];
    end
  end

  assign cs_s      = sync2_q[0];
  assign aclk_s    = sync2_q[1];
  assign done_s    = sync2_q[2];
  assign aclk_fall = aclk_prev_q & ~aclk_s;

  // ========================================================================
  // chip select deglitch
  logic       cs_lvl_q;
  logic       cs_lvl_d;
  logic       cand_q;
  logic       cand_d;
  logic [1:0] falls_q;
  logic [1:0] falls_d;

  always_comb begin
    cs_lvl_d = cs_lvl_q;
    cand_d   = cand_q;
    falls_d  = falls_q;
    if (cs_s == cs_lvl_q) begin
      cand_d  = cs_s;
      falls_d = '0;
    end else if (cs_s != cand_q) begin
      cand_d  = cs_s;
      falls_d = '0;
    end else if (aclk_fall) begin
      if (falls_q == 2'(`SACP_CS_FALLS - 2'h1)) begin
        cs_lvl_d = cand_q;
        falls_d  = '0;
      end else begin
        falls_d = 2'(falls_q + 2'h1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cs_lvl_q <= 1'h1;
      cand_q   <= 1'h1;
      falls_q  <= '0;
    end else begin
      cs_lvl_q <= cs_lvl_d;
      cand_q   <= cand_d;
      falls_q  <= falls_d;
    end
  end

  // ========================================================================
  // result buffer
  sacp_stream_if #(.W(RES_W)) res_if ();

  sacp_fifo #(
    .W     (RES_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst_n    (rst_n_q),
    .in_valid (res_valid),
    .in_ready (res_ready),
    .in_data  (res_data),
    .rd       (res_if.source)
  );

  // ========================================================================
  // output word formatting, index i is the i-th bit sent
  logic [CFG_W-1:0]  cfg_q;
  logic              uni_q;
  logic              uni_d;
  logic              order_q;
  logic              order_d;
  logic [RES_W-1:0]  code;
  logic [WORD_W-1:0] fmt_msb;
  logic [WORD_W-1:0] fmt_lsb;

  assign code = uni_q ? res_if.data
                      : {~res_if.data[RES_W-1], res_if.data[RES_W-2:0]};

  for (genvar i = 0; i < WORD_W; i++) begin : g_fmt
    if (i < RES_W) begin : g_data
      assign fmt_msb[i] = code[RES_W-1-i];
      assign fmt_lsb[i] = code[i];
    end else begin : g_fill
      assign fmt_msb[i] = 1'h0;
      assign fmt_lsb[i] = 1'h0;
    end
  end

  // ========================================================================
  // control state machine
  sacp_state_type    state_q;
  sacp_state_type    state_d;
  logic [WORD_W-1:0] word_q;
  logic [WORD_W-1:0] word_d;
  logic              start_q;
  logic              start_d;
  logic [3:0]        mux_q;
  logic [3:0]        mux_d;

  always_comb begin
    state_d = state_q;
    word_d  = word_q;
    start_d = 1'h0;
    mux_d   = mux_q;
    uni_d   = uni_q;
    order_d = order_q;
    unique case (state_q)
      sacp_idle: begin
        if (!cs_lvl_q) begin
          state_d = sacp_xfer;
        end
      end
      sacp_xfer: begin
        if (done_s) begin
          state_d = sacp_conv;
          start_d = 1'h1;
          mux_d   = cfg_q[`SACP_MUX_HI:`SACP_MUX_LO];
          uni_d   = cfg_q[`SACP_UNI_BIT];
          order_d = cfg_q[`SACP_ORDER_BIT];
        end else if (cs_lvl_q) begin
          state_d = sacp_idle;
        end
      end
      sacp_conv: begin
        if (res_if.valid) begin
          word_d  = order_q ? fmt_msb : fmt_lsb;
          state_d = cs_lvl_q ? sacp_idle : sacp_xfer;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= sacp_idle;
      word_q  <= '0;
      start_q <= 1'h0;
      mux_q   <= '0;
      uni_q   <= `SACP_UNI_RST;
      order_q <= `SACP_ORDER_RST;
    end else begin
      state_q <= state_d;
      word_q  <= word_d;
      start_q <= start_d;
      mux_q   <= mux_d;
      uni_q   <= uni_d;
      order_q <= order_d;
    end
  end

  assign res_if.ready  = (state_q == sacp_conv);
  assign conv_start    = start_q;
  assign conv_mux      = mux_q;
  assign conv_unipolar = uni_q;
  assign busy          = (state_q == sacp_conv);
  assign cs_active     = ~cs_lvl_q;

  // ========================================================================
  // shift clock domain, held in reset outside an active frame
  logic                   frame_rst_n;
  logic [`SACP_CNT_W-1:0] rcnt_q;
  logic [`SACP_CNT_W-1:0] rcnt_d;
  logic [CFG_W-1:0]       cfg_d;
  logic [CFG_W-1:0]       cfg_use;
  logic                   done_q;
  logic                   done_d;
  logic [`SACP_CNT_W-1:0] len;

  assign frame_rst_n = (state_q == sacp_xfer);

  always_comb begin
    rcnt_d  = rcnt_q;
    cfg_d   = cfg_q;
    done_d  = done_q;
    cfg_use = (rcnt_q < `SACP_CNT_W'(CFG_W)) ? {cfg_q[CFG_W-2:0], din}
                                             : cfg_q;
    if (rcnt_q < `SACP_CNT_W'(CFG_W)) begin
      cfg_d = cfg_use;
    end
    len = sacp_len_bits(cfg_use[`SACP_LEN_HI:`SACP_LEN_LO]);
    if (!done_q) begin
      rcnt_d = `SACP_CNT_W'(rcnt_q + 1'b1);
      if (rcnt_q >= `SACP_CFG_LAST &&
          `SACP_CNT_W'(rcnt_q + 1'b1) == len) begin
        done_d = 1'h1;
      end
    end
  end

  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      rcnt_q <= '0;
      cfg_q  <= '0;
      done_q <= 1'h0;
    end else begin
      rcnt_q <= rcnt_d;
      cfg_q  <= cfg_d;
      done_q <= done_d;
    end
  end

  assign done_lvl = done_q;

  // ------------------------------------------------------------------------
  // falling edges step the output bit; count saturates at bit 15, the last bit of a 16-bit word
  logic [`SACP_FCNT_W-1:0] fcnt_q;
  logic [`SACP_FCNT_W-1:0] fcnt_d;

  always_comb begin
    fcnt_d = fcnt_q;
    if (fcnt_q != `SACP_FCNT_W'(WORD_W - 1)) begin
      fcnt_d = `SACP_FCNT_W'(fcnt_q + 1'b1);
    end
  end

  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fcnt_q <= '0;
    end else begin
      fcnt_q <= fcnt_d;
    end
  end

  // ========================================================================
  // serial output; word_q is static during a frame so reading it is safe
  assign dout      = word_q[fcnt_q];
  assign dout_oe_n = ~frame_rst_n;

endmodule : sacp_control_port

//--- dv/sacp_port_checker.sv
`timescale 1ns/1ns
module sacp_port_checker #(
  parameter int RES_W      = 10,
  parameter int FIFO_DEPTH = 4
) (
  // system
  input wire logic       clk,
  input wire logic       resetn,
  // link
  input wire logic       cs_n,
  input wire logic       dout_oe_n,
  input wire logic       cs_active,
  // conversion
  input wire logic       conv_start,
  input wire logic [3:0] conv_mux,
  input wire logic       conv_unipolar,
  input wire logic       res_valid,
  input wire logic       busy
);
  // ========
  // cycles since cs_n last moved, saturating
  logic [3:0] stab_q, stab_d;
  logic       cs_q;
  always_comb begin
    stab_d = (stab_q == 4'hf) ? stab_q : stab_q + 4'h1;
    if (cs_n != cs_q) stab_d = 4'h0;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stab_q <= 4'h0;
      cs_q   <= 1'h1;
    end else begin
      stab_q <= stab_d;
      cs_q   <= cs_n;
    end
  end
  // ========
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  cs_filter_a: assert property (
    $changed(cs_active) |-> stab_q >= 4'h4)
    else $error("cs_active moved after a short cs_n level");
  oe_enable_a: assert property ($rose(cs_active) |=> !dout_oe_n)
    else $error("dout not enabled after select");
  oe_release_a: assert property (
    $fell(cs_active) |-> ##[0:2] dout_oe_n)
    else $error("dout still enabled after deselect");
  idle_quiet_a: assert property (
    !cs_active && !$past(cs_active) |-> dout_oe_n)
    else $error("dout enabled while deselected");
  start_pulse_a: assert property (
    conv_start |-> busy ##1 !conv_start)
    else $error("conv_start not a single pulse into busy");
  conv_quiet_a: assert property (busy |-> dout_oe_n)
    else $error("dout enabled during conversion");
  result_take_a: assert property (
    busy && res_valid |-> ##[1:3] !busy)
    else $error("result not taken");
  req_hold_a: assert property (
    $changed({conv_mux, conv_unipolar})
      |-> $past(conv_start) or ##[0:3] conv_start)
    else $error("request fields moved without a start");
endmodule : sacp_port_checker

bind sacp_control_port sacp_port_checker #(
  .RES_W(RES_W), .FIFO_DEPTH(FIFO_DEPTH)
) chk (
  .clk(clk), .resetn(resetn), .cs_n(cs_n), .dout_oe_n(dout_oe_n),
  .cs_active(cs_active), .conv_start(conv_start), .conv_mux(conv_mux),
  .conv_unipolar(conv_unipolar), .res_valid(res_valid), .busy(busy)
);

//--- dv/sacp_host_model.sv
`timescale 1ns/1ns
module sacp_host_model (
  // serial link
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout
);
  logic [15:0] rx;
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    din  = 1'h0;
    rx   = 16'h0;
  end
  // ========
  // one exchange; odd start delay keeps the link off the clk phase
  // n clocks, shift after fall, sample on rise
  task automatic frame(input logic [7:0] cfg, input int n, input bit hold);
    rx = 16'h0;
    cs_n <= 1'h0;
    #201;
    for (int i = 0; i < n; i++) begin
      din <= (i < 8) ? cfg[7 - i] : ~din;
      #16;
      sclk <= 1'h1;
      rx = {rx[14:0], dout};
      #16;
      sclk <= 1'h0;
    end
    // shift clock stays low, released data line flips
    din <= ~din;
    if (!hold) begin
      #40;
      cs_n <= 1'h1;
      #200;
    end
  endtask : frame
  // low pulse shorter than one conversion clock
  task automatic glitch();
    cs_n <= 1'h0;
    #10;
    cs_n <= 1'h1;
  endtask : glitch
endmodule : sacp_host_model

//--- dv/tb.sv
`timescale 1ns/1ns
module tb;
  // ========
  // rows: config sent, result converted, word received
  typedef struct {
    logic [7:0]  cfg;
    logic [9:0]  res;
    logic [15:0] exp;
  } sacp_row_type;
  sacp_row_type rows [6] = '{'{8'h5d, 10'h2b5, 16'h0000},
    '{8'hab, 10'h0c7, 16'had40}, '{8'h34, 10'h3ff, 16'h00e3},
    '{8'h02, 10'h001, 16'h07fc}, '{8'hfd, 10'h2a0, 16'h0201},
    '{8'h5d, 10'h000, 16'h02a0}};
  int bits [4] = '{8, 10, 12, 16};
  logic       clk, aclk, resetn, res_valid, res_ready, busy, cs_active;
  logic       sclk, cs_n, din, dout, dout_oe_n, conv_start, conv_unipolar;
  logic [3:0] conv_mux, wait_q, fill_n;
  logic [9:0] res_data, cur_res;
  logic [7:0] cur_cfg;
  int         error_cnt, checks_done;
  wire        dout_line = dout ^ dout_oe_n;
  always #2 clk = ~clk;
  always #12 aclk = ~aclk;
  sacp_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout_line));
  sacp_control_port dut (
    .clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .din(din),
    .aclk(aclk), .dout(dout), .dout_oe_n(dout_oe_n),
    .conv_start(conv_start), .conv_mux(conv_mux),
    .conv_unipolar(conv_unipolar), .res_valid(res_valid),
    .res_ready(res_ready), .res_data(res_data), .busy(busy),
    .cs_active(cs_active));
  // ========
  // helpers
  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic summarize();
    if (error_cnt == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  task automatic until_oe(input logic v);
    // look on the falling edge, away from the edge that moves the enable
    for (int i = 0; i < 200 && dout_oe_n !== v; i++) @(negedge clk);
    if (dout_oe_n !== v) begin
      chk("dout_oe_n wait", 16'(v), 16'(dout_oe_n));
      summarize();
    end
  endtask : until_oe
  // ========
  // converter: answers late so the wait state is seen; stuffs on demand
  always @(posedge clk) begin
    res_valid <= 1'h0;
    if (conv_start) begin
      wait_q <= 4'h8;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
      if (wait_q == 4'h1) begin
        res_valid <= 1'h1;
        res_data  <= cur_res;
        chk("conv_mux", 16'(cur_cfg[7:4]), 16'(conv_mux));
        chk("conv_unipolar", 16'(cur_cfg[3]), 16'(conv_unipolar));
      end
    end else if (fill_n != 4'h0) begin
      res_valid <= 1'h1;
      res_data  <= 10'h155;
      fill_n    <= fill_n - 4'h1;
    end
  end
  // ========
  // main sequence
  initial begin
    error_cnt = 0;
    checks_done = 0;
    clk = 1'h0;
    aclk = 1'h0;
    resetn = 1'h0;
    res_valid = 1'h0;
    res_data = 10'h0;
    cur_res = 10'h0;
    cur_cfg = 8'h0;
    wait_q = 4'h0;
    fill_n = 4'h0;
    repeat (3) @(posedge clk);
    resetn <= 1'h1;
    repeat (4) @(posedge clk);
    foreach (rows[k]) begin
      cur_cfg = rows[k].cfg;
      cur_res = rows[k].res;
      host.frame(rows[k].cfg, bits[rows[k].cfg[1:0]], 1'b0);
      chk("rx word", rows[k].exp, host.rx);
    end
    host.glitch();
    repeat (30) @(posedge clk);
    chk("cs_active", 16'h0, 16'(cs_active));
    chk("dout_oe_n", 16'h1, 16'(dout_oe_n));
    cur_cfg = 8'h4d;
    cur_res = 10'h3c1;
    host.frame(8'h4d, 10, 1'b1);
    chk("rx hold", 16'h0000, host.rx);
    until_oe(1'b1);
    until_oe(1'b0);
    chk("first bit", 16'h1, 16'(dout));
    host.frame(8'h4d, 10, 1'b0);
    chk("rx after hold", 16'h03c1, host.rx);
    // stale results pile up until the buffer refuses
    fill_n <= 4'h6;
    repeat (12) @(posedge clk);
    chk("res_ready full", 16'h0, 16'(res_ready));
    cur_cfg = 8'h5d;
    fork
      host.frame(8'h5d, 10, 1'b0);
    join_none
    repeat (100) @(posedge clk);
    resetn <= 1'h0;
    @(posedge clk);
    chk("oe in reset", 16'h1, 16'(dout_oe_n));
    chk("busy in reset", 16'h0, 16'(busy));
    repeat (200) @(posedge clk);
    resetn <= 1'h1;
    repeat (4) @(posedge clk);
    chk("res_ready empty", 16'h1, 16'(res_ready));
    cur_cfg = 8'h5d;
    host.frame(8'h5d, 10, 1'b0);
    chk("rx after reset", 16'h0000, host.rx);
    summarize();
  end
endmodule : tb
